// ---- verilog/exb_map.svh ----
// Offsets, field positions, reset values and timing counts of the expansion bus decoder.
// Assumes inclusion by name from the configuration store and decoder files.
`ifndef EXB_MAP_SVH
`define EXB_MAP_SVH

// Per chip-select configuration word fields
`define EXB_F_ENABLE    31
`define EXB_F_T1_HI     29
`define EXB_F_T1_LO     28
`define EXB_F_STYLE_HI  15
`define EXB_F_STYLE_LO  14
`define EXB_F_SIZE_HI   13
`define EXB_F_SIZE_LO   10
`define EXB_F_RDY_POL   5
`define EXB_F_MUX       4
`define EXB_F_WIDTH8    0

// Cycle style codes
`define EXB_STYLE_A     2'h0
`define EXB_STYLE_B     2'h1
`define EXB_STYLE_HPI   2'h2
`define EXB_STYLE_RSVD  2'h3

// Request size codes
`define EXB_SZ_BYTE     2'h0
`define EXB_SZ_HALF     2'h1
`define EXB_SZ_WORD     2'h2

// Address windows, top nibble of the system address, and region size base exponent
`define EXB_WIN_LOW     4'h0
`define EXB_WIN_SDRAM_TOP 4'h3
`define EXB_WIN_FIXED   4'h5
`define EXB_REGION_BASE 5'h09

// Reset values
`define EXB_OVL_RST     1'b1
`define EXB_CS0_RST     32'hb000_3c00
`define EXB_CSX_RST     32'h0000_0000

// Timing
`define EXB_CLK_NS      25
`define EXB_STRB_NS     50
`define EXB_STRB_CYC    ((`EXB_STRB_NS + `EXB_CLK_NS - 1) / `EXB_CLK_NS)

`endif

// ---- verilog/exb_pkg.sv ----
// Types shared by the expansion bus decoder files.
// Assumes nothing of its surroundings.
package exb_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_CFG, ST_SETUP, ST_ADDR, ST_STRB} exb_state_e;
   typedef logic [31:0] exb_word_t;
endpackage : exb_pkg

// ---- verilog/exb_cfg_if.sv ----
// Carrier between the decoder and its configuration store.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface exb_cfg_if;
   logic              wr_en;
   logic [2:0]        wr_idx;
   exb_pkg::exb_word_t wr_data;
   logic [2:0]        rd_idx;
   exb_pkg::exb_word_t rd_data;
   modport ctl (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
   modport mem (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface : exb_cfg_if

// ---- verilog/exb_cfg_mem.sv ----
// Eight chip-select configuration words with a registered read port.
// Assumes the same clock and reset as the decoder.
`timescale 1ns/1ps
`include "exb_map.svh"
module exb_cfg_mem #(
   parameter int unsigned NUM_CS = 8
) (
   // Clock and reset
   input  wire logic  core_clk_i,
   input  wire logic  rst_i,
   // Access port
   exb_cfg_if.mem     bus
);
   exb_pkg::exb_word_t cfg_q [NUM_CS];

   ////////////////////////////////////////////////////////////////////////////
   // One configuration word per chip select
   for (genvar i = 0; i < NUM_CS; i++) begin : g_cs
      always_ff @(posedge core_clk_i or posedge rst_i) begin
         if (rst_i) begin
            cfg_q[i] <= (i == 0) ? `EXB_CS0_RST : `EXB_CSX_RST;
         end else if (bus.wr_en && bus.wr_idx == 3'(i)) begin
            cfg_q[i] <= bus.wr_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered read
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bus.rd_data <= 32'h0000_0000;
      end else begin
         bus.rd_data <= cfg_q[bus.rd_idx];
      end
   end
endmodule : exb_cfg_mem

// ---- verilog/exb_decode.sv ----
// Expansion bus decode, chip selects, control styles, wait handling and byte steering.
// Assumes a single-beat system-bus master that holds no request while busy_o is high.
`timescale 1ns/1ps
`include "exb_map.svh"

// How it works
// - Address with latch strobe for one or two cycles plus zero to three extra.
// - Style B turns write strobe into data strobe, read strobe into read-not-write.
// - Shared active-low wait stretches the strobe phase on any strobe-style select.
// - Selects 4-7 own a ready input; host-port mode listens only to it.
// - Host-port style is legal only on selects 4 to 7.
// - Overlap bit sends the lowest 256 MB to the expansion bus, else SDRAM.
// - Overlap bit resets to one so the boot fetch reaches flash.
// - Window 0x50000000-0x5fffffff always reaches the expansion bus.
// - External address bits 23:0 follow system address bits 23:0, except bits 1:0 count beats on word accesses.
// - Address bits 26:24 pick one of eight 16 MB selects; bit 27 ignored.
// - Region size is two to the nine plus size field bits 13:10.
// - Word writes, halfwords on 8-bit and byte writes on 16-bit are refused.
// - Word read of 8-bit device takes four byte cycles, top lane first.
// - On 16-bit devices address bit 1 low maps to bits 31:16.
// - Byte access on 8-bit devices uses the lane picked by address bits 1:0.
// - Eight independent configuration words, one per chip select.
// - Bits 15:14 pick cycle style; strobe styles allow multiplexed or separate.
// - Style 00 is A, 01 is B, 10 host-port, 11 reserved.
// - Bit 4 set means multiplexed address and data.
// - Bit 0 set means 8-bit device, clear means 16-bit.
// - Bit 31 enables the chip select.
module exb_decode (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // System-bus request and answer
   input  wire logic        req_valid_i,
   input  wire logic [31:0] req_addr_i,
   input  wire logic        req_write_i,
   input  wire logic [1:0]  req_size_i,
   input  wire logic [31:0] req_wdata_i,
   output logic             busy_o,
   output logic             sdram_sel_o,
   output logic             resp_valid_o,
   output logic             resp_error_o,
   output logic [31:0]      resp_rdata_o,
   // Configuration
   input  wire logic        overlap_wr_i,
   input  wire logic        overlap_val_i,
   output logic             overlap_sel_o,
   input  wire logic        cfg_wr_i,
   input  wire logic [2:0]  cfg_idx_i,
   input  wire logic [31:0] cfg_data_i,
   // Expansion bus pins
   output logic [23:0]      ext_addr_bus_o,
   output logic             addr_latch_strobe_o,
   output logic [7:0]       chip_sel_n_o,
   output logic             write_strobe_n_o,
   output logic             read_strobe_n_o,
   output logic [15:0]      ext_data_o,
   output logic             ext_data_oe_o,
   input  wire logic [15:0] ext_data_i,
   input  wire logic        shared_wait_n_i,
   input  wire logic [3:0]  dsp_ready_in_i
);
   exb_pkg::exb_state_e state_q;
   logic [31:0]         addr_q;
   logic                write_q;
   logic [1:0]          size_q;
   logic [31:0]         wdata_q;
   logic [31:0]         rdata_q;
   logic [1:0]          beat_q;
   logic [2:0]          cnt_q;
   logic                overlap_q;
   logic [20:0]         sync1_q;
   logic [20:0]         sync2_q;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration store
   exb_cfg_if cfg_bus ();
   assign cfg_bus.wr_en   = cfg_wr_i;
   assign cfg_bus.wr_idx  = cfg_idx_i;
   assign cfg_bus.wr_data = cfg_data_i;
   assign cfg_bus.rd_idx  = (state_q == exb_pkg::ST_IDLE) ? req_addr_i[26:24] : addr_q[26:24];

   exb_cfg_mem #(
      .NUM_CS (8)
   ) u_cfg_mem (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .bus        (cfg_bus.mem)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin input synchronisers
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_q <= 21'h1f_ffff;
         sync2_q <= 21'h1f_ffff;
      end else begin
         sync1_q <= {dsp_ready_in_i, shared_wait_n_i, ext_data_i};
         sync2_q <= sync1_q;
      end
   end

   wire logic [15:0] data_s = sync2_q[15:0];
   wire logic        wait_n_s = sync2_q[16];
   wire logic [3:0]  ready_s = sync2_q[20:17];

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   wire logic [3:0] win      = req_addr_i[31:28];
   wire logic       low_exp  = (win == `EXB_WIN_LOW) && overlap_q;
   wire logic       hit_exp  = low_exp || (win == `EXB_WIN_FIXED);
   wire logic       hit_sdr  = (win <= `EXB_WIN_SDRAM_TOP) && !low_exp;
   wire logic       take     = (state_q == exb_pkg::ST_IDLE) && req_valid_i;
   wire logic [2:0] cs_idx   = addr_q[26:24];

   ////////////////////////////////////////////////////////////////////////////
   // Selected configuration fields
   wire logic [31:0] cfg     = cfg_bus.rd_data;
   wire logic        cs_en   = cfg[`EXB_F_ENABLE];
   wire logic [1:0]  t1      = cfg[`EXB_F_T1_HI:`EXB_F_T1_LO];
   wire logic [1:0]  style   = cfg[`EXB_F_STYLE_HI:`EXB_F_STYLE_LO];
   wire logic [3:0]  rsize   = cfg[`EXB_F_SIZE_HI:`EXB_F_SIZE_LO];
   wire logic        rdy_pol = cfg[`EXB_F_RDY_POL];
   wire logic        mux     = cfg[`EXB_F_MUX];
   wire logic        w8      = cfg[`EXB_F_WIDTH8];
   wire logic        is_hpi  = (style == `EXB_STYLE_HPI);
   wire logic        is_b    = (style == `EXB_STYLE_B);

   ////////////////////////////////////////////////////////////////////////////
   // Legality checks
   wire logic [4:0]  sh         = `EXB_REGION_BASE + {1'b0, rsize};
   wire logic [24:0] limit      = 25'h000_0001 << sh;
   wire logic        out_region = {1'b0, addr_q[23:0]} >= limit;
   wire logic        style_bad  = (style == `EXB_STYLE_RSVD) || (is_hpi && !cs_idx[2]);
   wire logic        size_bad   = (size_q == `EXB_SZ_WORD && write_q)
                                  || (w8 && size_q == `EXB_SZ_HALF)
                                  || (!w8 && size_q == `EXB_SZ_BYTE && write_q)
                                  || (size_q == 2'h3);
   wire logic        reject     = !cs_en || style_bad || size_bad || out_region;

   ////////////////////////////////////////////////////////////////////////////
   // Beats, address low bits and lane steering
   wire logic       is_word   = (size_q == `EXB_SZ_WORD);
   wire logic [1:0] last_beat = is_word ? (w8 ? 2'h3 : 2'h1) : 2'h0;
   wire logic [1:0] lo        = is_word ? (w8 ? beat_q : {beat_q[0], 1'b0}) : addr_q[1:0];
   wire logic [4:0] lane_base = w8 ? {~lo, 3'b000} : {~lo[1], 4'b0000};
   wire logic [15:0] wr_out   = w8 ? {8'h00, wdata_q[lane_base +: 8]} : wdata_q[lane_base +: 16];
   wire logic [2:0] alen_m1   = {2'b00, mux} + {1'b0, t1};
   wire logic       holdoff   = is_hpi ? (ready_s[cs_idx[1:0]] != rdy_pol) : !wait_n_s;
   wire logic [7:0] cs_onehot = 8'h01 << cs_idx;

   ////////////////////////////////////////////////////////////////////////////
   // Overlap select
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         overlap_q <= `EXB_OVL_RST;
      end else if (overlap_wr_i) begin
         overlap_q <= overlap_val_i;
      end
   end
   assign overlap_sel_o = overlap_q;

   ////////////////////////////////////////////////////////////////////////////
   // Cycle sequencer
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q             <= exb_pkg::ST_IDLE;
         addr_q              <= 32'h0000_0000;
         write_q             <= 1'b0;
         size_q              <= 2'h0;
         wdata_q             <= 32'h0000_0000;
         rdata_q             <= 32'h0000_0000;
         beat_q              <= 2'h0;
         cnt_q               <= 3'h0;
         busy_o              <= 1'b0;
         sdram_sel_o         <= 1'b0;
         resp_valid_o        <= 1'b0;
         resp_error_o        <= 1'b0;
         ext_addr_bus_o      <= 24'h00_0000;
         addr_latch_strobe_o <= 1'b0;
         chip_sel_n_o        <= 8'hff;
         write_strobe_n_o    <= 1'b1;
         read_strobe_n_o     <= 1'b1;
         ext_data_o          <= 16'h0000;
         ext_data_oe_o       <= 1'b0;
      end else begin
         sdram_sel_o  <= 1'b0;
         resp_valid_o <= 1'b0;
         resp_error_o <= 1'b0;
         case (state_q)
            exb_pkg::ST_IDLE: begin
               if (take) begin
                  addr_q  <= req_addr_i;
                  write_q <= req_write_i;
                  size_q  <= req_size_i;
                  wdata_q <= req_wdata_i;
                  rdata_q <= 32'h0000_0000;
                  beat_q  <= 2'h0;
                  if (hit_exp) begin
                     state_q <= exb_pkg::ST_CFG;
                     busy_o  <= 1'b1;
                  end else if (hit_sdr) begin
                     sdram_sel_o <= 1'b1;
                  end
               end
            end
            exb_pkg::ST_CFG: begin
               if (reject) begin
                  resp_valid_o <= 1'b1;
                  resp_error_o <= 1'b1;
                  busy_o       <= 1'b0;
                  state_q      <= exb_pkg::ST_IDLE;
               end else begin
                  state_q <= exb_pkg::ST_SETUP;
               end
            end
            exb_pkg::ST_SETUP: begin
               state_q             <= exb_pkg::ST_ADDR;
               cnt_q               <= alen_m1;
               ext_addr_bus_o      <= {addr_q[23:2], lo};
               addr_latch_strobe_o <= 1'b1;
               chip_sel_n_o        <= ~cs_onehot;
               read_strobe_n_o     <= is_b ? !write_q : 1'b1;
               ext_data_o          <= {addr_q[15:2], lo};
               ext_data_oe_o       <= mux;
            end
            exb_pkg::ST_ADDR: begin
               if (cnt_q == 3'h0) begin
                  state_q             <= exb_pkg::ST_STRB;
                  cnt_q               <= 3'(`EXB_STRB_CYC - 1);
                  addr_latch_strobe_o <= 1'b0;
                  ext_data_o          <= wr_out;
                  ext_data_oe_o       <= write_q;
                  write_strobe_n_o    <= !(write_q || is_b);
                  read_strobe_n_o     <= is_b ? !write_q : write_q;
               end else begin
                  cnt_q               <= cnt_q - 3'h1;
                  addr_latch_strobe_o <= (cnt_q > 3'h1);
                  ext_data_o          <= wr_out;
                  ext_data_oe_o       <= write_q;
               end
            end
            exb_pkg::ST_STRB: begin
               if (cnt_q != 3'h0) begin
                  cnt_q <= cnt_q - 3'h1;
               end else if (!holdoff) begin
                  if (w8) begin
                     rdata_q[lane_base +: 8] <= data_s[7:0];
                  end else begin
                     rdata_q[lane_base +: 16] <= data_s;
                  end
                  chip_sel_n_o     <= 8'hff;
                  write_strobe_n_o <= 1'b1;
                  read_strobe_n_o  <= 1'b1;
                  ext_data_oe_o    <= 1'b0;
                  if (beat_q == last_beat) begin
                     state_q      <= exb_pkg::ST_IDLE;
                     busy_o       <= 1'b0;
                     resp_valid_o <= 1'b1;
                  end else begin
                     beat_q  <= beat_q + 2'h1;
                     state_q <= exb_pkg::ST_SETUP;
                  end
               end
            end
            default: begin
               state_q <= exb_pkg::ST_IDLE;
            end
         endcase
      end
   end
   assign resp_rdata_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_word_write;
      take && hit_exp && req_size_i == `EXB_SZ_WORD && req_write_i;
   endsequence

   sequence s_low_to_sdram;
      take && win == `EXB_WIN_LOW && !overlap_q;
   endsequence

   sequence s_strobe_held;
      state_q == exb_pkg::ST_STRB && cnt_q == 3'h0 && holdoff;
   endsequence

   a_ale_early_drop: assert property (
      (state_q == exb_pkg::ST_ADDR && cnt_q == 3'h0 && alen_m1 != 3'h0) |-> !addr_latch_strobe_o)
      else $error("latch strobe still high in last address cycle");
   a_style_b_pins: assert property (
      (state_q == exb_pkg::ST_STRB && is_b) |-> (!write_strobe_n_o && read_strobe_n_o == !write_q))
      else $error("data strobe style pins wrong");
   a_wait_stretch: assert property (
      s_strobe_held |=> (state_q == exb_pkg::ST_STRB && $stable(chip_sel_n_o)))
      else $error("strobe phase ended while held off");
   a_hpi_ready_only: assert property (
      (state_q == exb_pkg::ST_STRB && cnt_q == 3'h0 && is_hpi && !wait_n_s
       && ready_s[cs_idx[1:0]] == rdy_pol) |=> state_q != exb_pkg::ST_STRB)
      else $error("host-port select stalled by shared wait");
   a_hpi_low_cs: assert property (
      state_q == exb_pkg::ST_ADDR |-> !(is_hpi && !cs_idx[2]))
      else $error("host-port cycle on a low chip select");
   a_low_route: assert property (
      s_low_to_sdram |=> (sdram_sel_o && !busy_o))
      else $error("low window not routed to sdram");
   a_overlap_boot: assert property (
      $fell(overlap_sel_o) |-> $past(overlap_wr_i && !overlap_val_i))
      else $error("overlap bit cleared without a write");
   a_fixed_window: assert property (
      (take && win == `EXB_WIN_FIXED) |=> (state_q == exb_pkg::ST_CFG && busy_o))
      else $error("fixed window not decoded");
   a_addr_pins: assert property (
      state_q == exb_pkg::ST_ADDR |-> ext_addr_bus_o[23:2] == addr_q[23:2])
      else $error("external address differs from request");
   a_cs_one_hot: assert property (
      state_q == exb_pkg::ST_STRB |-> chip_sel_n_o == ~cs_onehot)
      else $error("wrong chip select asserted");
   a_region_limit: assert property (
      (state_q == exb_pkg::ST_CFG && out_region) |=> (resp_error_o && chip_sel_n_o == 8'hff))
      else $error("access outside region not refused");
   a_word_write: assert property (
      s_word_write |-> ##2 (resp_valid_o && resp_error_o && chip_sel_n_o == 8'hff))
      else $error("word write not refused");
   a_byte_beats: assert property (
      (state_q == exb_pkg::ST_ADDR && is_word && w8) |-> ext_addr_bus_o[1:0] == beat_q)
      else $error("byte beat address wrong");
endmodule : exb_decode

// ---- test/exb_periph_model.sv ----
// Behavioural peripheral on the expansion bus pins: answers reads, records writes, holds off.
// Assumes the pins of exb_decode and the same clock.
`timescale 1ns/1ps
module exb_periph_model (
   // Clock, pins from the decoder and hold count from the bench
   input  wire logic        core_clk_i,
   input  wire logic [23:0] ext_addr_bus_i,
   input  wire logic        addr_latch_strobe_i,
   input  wire logic [7:0]  chip_sel_n_i,
   input  wire logic        write_strobe_n_i,
   input  wire logic        read_strobe_n_i,
   input  wire logic [15:0] ext_data_i,
   input  wire logic        ext_data_oe_i,
   input  wire logic [3:0]  hold_cyc_i,
   // Pins to the decoder
   output logic [15:0]      ext_data_o,
   output logic             shared_wait_n_o,
   output logic [3:0]       dsp_ready_in_o,
   // Observations
   output logic [15:0]      wr_seen_o,
   output logic             rnw_seen_o,
   output logic [23:0]      ale_addr_o,
   output logic [15:0]      ale_data_o,
   output logic [7:0]       ale_cs_o,
   output logic [3:0]       ale_cnt_o
);
   logic [15:0] last_q = 16'h0;
   logic [3:0]  sel_cnt_q = 4'h0;
   logic        wr_n_q = 1'b1;
   logic        ale_q = 1'b0;
   wire         sel = chip_sel_n_i != 8'hff;
   wire         held = sel && (sel_cnt_q < hold_cyc_i);
   // Selected device answers from its address, a released bus shows the inverse of the last value driven
   assign ext_data_o = (sel && !ext_data_oe_i) ? {ext_addr_bus_i[7:0] ^ 8'ha5, ext_addr_bus_i[7:0] ^ 8'h5a} : ~last_q;
   // Wait answers the chip select at once; hold count f leaves it stuck low so only ready ends a cycle
   assign shared_wait_n_o = !(held || (sel && hold_cyc_i == 4'hf));
   assign dsp_ready_in_o = {4{!held}};
   always @(posedge core_clk_i) begin
      if (sel && !ext_data_oe_i) begin
         last_q <= ext_data_o;
      end
      wr_n_q <= write_strobe_n_i;
      ale_q <= addr_latch_strobe_i;
      if (!sel) begin
         sel_cnt_q <= 4'h0;
      end else if (sel_cnt_q != 4'hf) begin
         sel_cnt_q <= sel_cnt_q + 4'h1;
      end
      if (wr_n_q && !write_strobe_n_i) begin
         rnw_seen_o <= read_strobe_n_i;
      end
      if (!write_strobe_n_i && ext_data_oe_i) begin
         wr_seen_o <= ext_data_i;
      end
      if (addr_latch_strobe_i) begin
         ale_addr_o <= ext_addr_bus_i;
         ale_data_o <= ext_data_i;
         ale_cs_o <= chip_sel_n_i;
         ale_cnt_o <= ale_q ? ale_cnt_o + 4'h1 : 4'h1;
      end
   end
endmodule : exb_periph_model

// ---- test/test_expansion_bus_decode_steering.sv ----
// Self-checking bench for the expansion bus decoder with a behavioural peripheral.
// Assumes the design files and the peripheral model are compiled before it.
`timescale 1ns/1ps
module test_expansion_bus_decode_steering;
   logic        core_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        req_valid_i = 1'b0, req_write_i = 1'b0, overlap_wr_i = 1'b0, overlap_val_i = 1'b0, cfg_wr_i = 1'b0;
   logic [31:0] req_addr_i = 32'h0, req_wdata_i = 32'h0, cfg_data_i = 32'h0;
   logic [1:0]  req_size_i = 2'h0;
   logic [2:0]  cfg_idx_i = 3'h0;
   logic [3:0]  hold_cyc = 4'h0;
   logic        busy_o, sdram_sel_o, resp_valid_o, resp_error_o, overlap_sel_o, addr_latch_strobe_o;
   logic        write_strobe_n_o, read_strobe_n_o, ext_data_oe_o, shared_wait_n_i, rnw_seen, err;
   logic [31:0] resp_rdata_o, rd;
   logic [23:0] ext_addr_bus_o, ale_addr;
   logic [15:0] ext_data_o, ext_data_i, wr_seen, ale_data;
   logic [7:0]  chip_sel_n_o, ale_cs;
   logic [3:0]  dsp_ready_in_i, ale_cnt;
   int          miscompares = 0;
   int          checked = 0;
   int          lat, lat0;

   exb_decode dut (.core_clk_i, .rst_i, .req_valid_i, .req_addr_i, .req_write_i, .req_size_i, .req_wdata_i,
      .busy_o, .sdram_sel_o, .resp_valid_o, .resp_error_o, .resp_rdata_o, .overlap_wr_i, .overlap_val_i,
      .overlap_sel_o, .cfg_wr_i, .cfg_idx_i, .cfg_data_i, .ext_addr_bus_o, .addr_latch_strobe_o, .chip_sel_n_o,
      .write_strobe_n_o, .read_strobe_n_o, .ext_data_o, .ext_data_oe_o, .ext_data_i, .shared_wait_n_i,
      .dsp_ready_in_i);
   exb_periph_model periph (.core_clk_i(core_clk_i), .ext_addr_bus_i(ext_addr_bus_o),
      .addr_latch_strobe_i(addr_latch_strobe_o), .chip_sel_n_i(chip_sel_n_o), .write_strobe_n_i(write_strobe_n_o),
      .read_strobe_n_i(read_strobe_n_o), .ext_data_i(ext_data_o), .ext_data_oe_i(ext_data_oe_o),
      .hold_cyc_i(hold_cyc), .ext_data_o(ext_data_i), .shared_wait_n_o(shared_wait_n_i),
      .dsp_ready_in_o(dsp_ready_in_i), .wr_seen_o(wr_seen), .rnw_seen_o(rnw_seen), .ale_addr_o(ale_addr),
      .ale_data_o(ale_data), .ale_cs_o(ale_cs), .ale_cnt_o(ale_cnt));

   initial begin
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] f16(input logic [7:0] a);
      return {a ^ 8'ha5, a ^ 8'h5a};
   endfunction : f16
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   task automatic cfg(input logic [2:0] idx, input logic [31:0] val);
      @(negedge core_clk_i);
      cfg_wr_i = 1'b1;
      cfg_idx_i = idx;
      cfg_data_i = val;
      @(negedge core_clk_i);
      cfg_wr_i = 1'b0;
   endtask : cfg
   // One request, held across its taking edge, then a bounded wait for the answer
   task automatic req(input logic [31:0] a, input logic w, input logic [1:0] s, input logic [31:0] wd);
      @(negedge core_clk_i);
      for (int i = 0; i < 20 && busy_o !== 1'b0; i++) @(negedge core_clk_i);
      if (busy_o !== 1'b0) begin
         miscompares++;
         give_verdict();
      end
      req_valid_i = 1'b1;
      req_addr_i = a;
      req_write_i = w;
      req_size_i = s;
      req_wdata_i = wd;
      @(negedge core_clk_i);
      req_valid_i = 1'b0;
      lat = 0;
      while (lat < 400 && resp_valid_o !== 1'b1 && sdram_sel_o !== 1'b1) begin
         @(negedge core_clk_i);
         lat++;
      end
      if (lat == 400) begin
         miscompares++;
         give_verdict();
      end
      rd = resp_rdata_o;
      err = resp_error_o;
   endtask : req
   task automatic refuse(input logic [31:0] a, input logic w, input logic [1:0] s);
      req(a, w, s, 32'h0);
      chk("refused", {31'h0, err}, 32'h1);
   endtask : refuse

   ////////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(negedge core_clk_i);
      rst_i = 1'b0;
      chk("overlap reset", {31'h0, overlap_sel_o}, 32'h1);
      cfg(3'h1, 32'h8000_3c01);
      cfg(3'h3, 32'h8000_8000);
      cfg(3'h4, 32'h8000_bc20);
      cfg(3'h5, 32'h8000_7c00);
      cfg(3'h6, 32'h8000_0010);
      cfg(3'h7, 32'h8000_fc00);
      req(32'h0000_0004, 1'b0, 2'h2, 32'h0);
      chk("boot word", rd, {f16(8'h04), f16(8'h06)});
      chk("boot select", {24'h0, ale_cs}, 32'hfe);
      req(32'h5100_0010, 1'b0, 2'h2, 32'h0);
      chk("byte word", rd, {8'h10 ^ 8'h5a, 8'h11 ^ 8'h5a, 8'h12 ^ 8'h5a, 8'h13 ^ 8'h5a});
      req(32'h5912_3402, 1'b0, 2'h0, 32'h0);
      lat0 = lat;
      chk("byte lane", {24'h0, rd[15:8]}, {24'h0, 8'h02 ^ 8'h5a});
      chk("ext addr", {8'h0, ale_addr}, 32'h0012_3402);
      chk("alias select", {24'h0, ale_cs}, 32'hfd);
      chk("ale width", {28'h0, ale_cnt}, 32'h1);
      hold_cyc = 4'h6;
      req(32'h5912_3402, 1'b0, 2'h0, 32'h0);
      chk("wait data", {24'h0, rd[15:8]}, {24'h0, 8'h02 ^ 8'h5a});
      chk("wait stretch", {31'h0, lat > lat0 + 2}, 32'h1);
      hold_cyc = 4'hf;
      req(32'h5400_0002, 1'b0, 2'h1, 32'h0);
      chk("host read", {16'h0, rd[15:0]}, {16'h0, f16(8'h02)});
      hold_cyc = 4'h0;
      req(32'h5100_0001, 1'b1, 2'h0, 32'h1122_3344);
      chk("byte write", {24'h0, wr_seen[7:0]}, 32'h22);
      chk("style a rnw", {31'h0, rnw_seen}, 32'h1);
      req(32'h5500_0002, 1'b1, 2'h1, 32'haabb_ccdd);
      chk("half write", {16'h0, wr_seen}, 32'hccdd);
      chk("style b rnw", {31'h0, rnw_seen}, 32'h0);
      req(32'h5500_0000, 1'b0, 2'h1, 32'h0);
      chk("style b read", {16'h0, rd[31:16]}, {16'h0, f16(8'h00)});
      req(32'h5600_01fe, 1'b0, 2'h1, 32'h0);
      chk("mux read", {16'h0, rd[15:0]}, {16'h0, f16(8'hfe)});
      chk("mux addr", {16'h0, ale_data}, 32'h01fe);
      refuse(32'h5100_0000, 1'b1, 2'h2);
      refuse(32'h5100_0000, 1'b0, 2'h1);
      refuse(32'h5000_0001, 1'b1, 2'h0);
      refuse(32'h5200_0000, 1'b0, 2'h0);
      refuse(32'h5300_0000, 1'b0, 2'h1);
      refuse(32'h5700_0000, 1'b0, 2'h1);
      refuse(32'h5600_0200, 1'b0, 2'h1);
      refuse(32'h5100_0000, 1'b0, 2'h3);
      overlap_wr_i = 1'b1;
      @(negedge core_clk_i);
      overlap_wr_i = 1'b0;
      chk("overlap clear", {31'h0, overlap_sel_o}, 32'h0);
      req(32'h0000_0000, 1'b0, 2'h2, 32'h0);
      chk("sdram route", {30'h0, sdram_sel_o, resp_valid_o}, 32'h2);
      req(32'h5000_0000, 1'b0, 2'h2, 32'h0);
      chk("fixed window", rd, {f16(8'h00), f16(8'h02)});
      give_verdict();
   end
endmodule : test_expansion_bus_decode_steering
